// ==== core/ebt_pkg.sv ====
/*
 * Shared constants and types for the emulator break and trace-frame unit.
 * Assumes a single 100 MHz clock and host-side software that drives the control ports.
 */
package ebt_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int NUM_BP = 10;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int MISC_W = 8;
   localparam int PORT_W = 8;
   localparam int FRAME_W = 48;
   localparam int TS_W = 16;
   localparam int LVL_W = 3;
   // Bits of the cycle-type select.
   localparam int SEL_FETCH = 0;
   localparam int SEL_READ = 1;
   localparam int SEL_WRITE = 2;
   // Bits of the go control register.
   localparam int GO_BP_EN = 0;
   localparam int GO_SYNC_EN = 1;
   localparam int GO_SYNC_AND = 2;
   // Strobe bits of port three.
   localparam int P3_RD_BIT = 7;
   localparam int P3_WR_BIT = 6;
   // Trace lag in fetch strobes and the timer over-run/pre-start figures.
   localparam int TRACE_LAG_FETCHES = 2;
   localparam int TIMER_OVERRUN_CYC = 3;
   localparam int TIMER_PRESTART_CYC = 2;
   localparam logic [TS_W-1:0] TS_RESET = 16'h0000;
   typedef enum logic [1:0] {EBT_CY_NONE, EBT_CY_FETCH, EBT_CY_READ, EBT_CY_WRITE} ebt_cycle_e;
   typedef enum logic [2:0] {EBT_SRC_NONE, EBT_SRC_ADDR, EBT_SRC_SYNC, EBT_SRC_TRACE,
                             EBT_SRC_STROBE, EBT_SRC_STOP} ebt_src_e;
   typedef struct packed {
      logic overflow;
      ebt_cycle_e cyc;
      logic first_fetch;
      logic [LVL_W-1:0] level;
      logic [3:0] sync_ext;
      logic [FRAME_W-1:0] frame;
      logic [TS_W-1:0] ts_abs;
      logic [TS_W-1:0] ts_rel;
   } ebt_rec_s;
endpackage

// ==== core/ebt_buf_if.sv ====
/*
 * Valid/ready carrier for trace records between the unit and its buffer.
 * Assumes both ends share the system clock.
 */
interface ebt_buf_if;
   import ebt_pkg::*;
   logic valid;
   logic ready;
   ebt_rec_s data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ==== core/ebt_skid.sv ====
/*
 * Two-entry buffer for trace records, so a stalled reader loses no record.
 * Assumes asynchronous active-low reset already released cleanly.
 */
module ebt_skid
   import ebt_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   ebt_buf_if.snk up,
   ebt_buf_if.src dn
);
   typedef struct packed {
      ebt_rec_s [1:0] ent;
      logic [1:0] cnt;
      logic rd;
      logic wr;
   } ebt_skid_s;
   ebt_skid_s st_q, st_d;
   logic push, pop;

   // The count never passes two, so ready reflects true free space.
   always_comb begin
      st_d = st_q;
      push = up.valid && (st_q.cnt != 2'h2);
      pop = (st_q.cnt != 2'h0) && dn.ready;
      if (push) begin
         st_d.ent[st_q.wr] = up.data;
         st_d.wr = ~st_q.wr;
      end
      if (pop) begin
         st_d.rd = ~st_q.rd;
      end
      st_d.cnt = st_q.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign up.ready = (st_q.cnt != 2'h2);
   assign dn.valid = (st_q.cnt != 2'h0);
   assign dn.data = st_q.ent[st_q.rd];

   AST_NO_OVERFILL: assert property (@(posedge clk) disable iff (!rst_n) st_q.cnt <= 2'h2)
      else $error("Buffer count exceeded two.");
endmodule

// ==== core/ebt_unit.sv ====
/*
 * Break decision and trace-frame tagging for an in-circuit emulator.
 * Assumes the pod presents one bus cycle per i_cyc_vld pulse, synchronous to I_SYS_CLK,
 * and that host software drives the control ports between runs.
 */
// Overview of operation
// RULE1: Break on fetch, external read or external write address matches.
// RULE2: Ten breakpoint address registers, indices zero to nine.
// RULE3: Cycle-type select chooses which cycle kinds address compares apply to.
// RULE4: Address breaks act only once enabled by go control or start command.
// RULE5: Sync input zero breaks, with selectable polarity, alone or with breakpoints.
// RULE6: With trace-break enabled, a full 48-bit frame match raises a break.
// RULE7: Trace-triggered break lands one instruction late due to trace lag.
// RULE8: External pods break when read or write strobe bit is written zero.
// RULE9: Address-break instruction completes; stop lands at the next fetch.
// RULE10: Breakpoint memory cleared on go, line-run or explicit clear command; the code clears it only on the clear command.
// RULE11: Conditional breaks hand control to host, which tests and resumes.
// RULE12: Host stop request halts emulation immediately.
// RULE13: Each frame is classed fetch, read, write or none.
// RULE14: Timestamp overflow forces a stored frame marked overflow.
// RULE15: Each frame records interrupt level; zero is main program.
// RULE16: Frames record port one, port three, two sync and two external inputs.
// RULE17: Frames carry absolute and relative timestamps.
// RULE18: First-fetch flag set only on an instruction's first frame.
// RULE19: External pods: timers over-run after break and pre-start before resume; the code starts them on the same clock as the run.
// RULE20: Bond-out or internal-code pods show no timer over-run or pre-start.
// RULE21: Frame holds 16 address, 8 data, 8 misc, 8 port one, 8 port three bits.
// RULE22: Halting emulation also stops trace capture.
// RULE23: Stop is the OR of enabled sources; the cause is latched.
module ebt_unit
   import ebt_pkg::*;
#(
   parameter int NBP = NUM_BP
) (
   // Clock and reset.
   input wire logic I_SYS_CLK,
   input wire logic I_ARST_N,
   // Host control.
   input wire logic I_START,
   input wire logic I_STOP_REQ,
   input wire logic I_CLEAR_BREAKS_CMD,
   input wire logic I_CONDITIONAL_BREAK_CMD,
   input wire logic I_BP_WR,
   input wire logic [3:0] I_BP_IDX,
   input wire logic [ADDR_W-1:0] I_BP_ADDR,
   input wire logic [2:0] I_BP_CYCLE_TYPE_SELECT,
   input wire logic [2:0] I_GO_CONTROL_REG,
   input wire logic I_SYNC_POLARITY_SELECT,
   input wire logic I_TRACE_BREAK_ENABLE,
   input wire logic [FRAME_W-1:0] I_TRIG_VALUE,
   input wire logic I_EXT_POD,
   input wire logic I_TS_TIME_MODE,
   // Target bus cycle.
   input wire logic I_CYC_VLD,
   input wire logic [1:0] I_CYC_KIND,
   input wire logic [ADDR_W-1:0] I_ADDR,
   input wire logic [DATA_W-1:0] I_DATA,
   input wire logic [MISC_W-1:0] I_MISC,
   input wire logic [PORT_W-1:0] I_P1,
   input wire logic [PORT_W-1:0] I_P3,
   input wire logic [LVL_W-1:0] I_INT_LEVEL,
   input wire logic I_SYNC_IN_ZERO,
   input wire logic I_SYNC_IN_ONE,
   input wire logic I_EXT_INPUT_ZERO,
   input wire logic I_EXT_INPUT_ONE,
   // Trace record stream.
   input wire logic I_REC_READY,
   output logic O_REC_VALID,
   output ebt_rec_s O_REC_DATA,
   // Emulation status.
   output logic O_RUNNING,
   output logic O_BREAK,
   output ebt_src_e O_BREAK_CAUSE,
   output logic O_COND_BREAK,
   output logic O_TIMER_RUN,
   output logic O_TRACE_ON
);
   typedef enum logic [1:0] {EBT_IDLE, EBT_RUN, EBT_HALT} ebt_state_e;
   typedef struct packed {
      logic [1:0] rst_sync;
      ebt_state_e state;
      logic bp_armed;
      logic [NBP-1:0] bp_valid;
      logic addr_hit;
      logic [1:0] trace_lag;
      logic trace_pend;
      ebt_src_e cause;
      logic cond;
      logic cond_run;
      logic [2:0] tmr_cnt;
      logic tmr_run;
      logic [TS_W-1:0] ts_abs;
      logic [TS_W-1:0] ts_last;
      logic ovf;
      logic running;
      logic brk;
      logic trace_on;
   } ebt_unit_s;

   ebt_unit_s st_q, st_d;
   logic [ADDR_W-1:0] bp_mem [NBP];
   logic rst_n;
   logic [NBP-1:0] bp_match;
   logic cyc_sel, addr_src, sync_act, sync_src, trace_hit, strobe_low;
   logic [FRAME_W-1:0] frame;
   logic [TS_W-1:0] ts_next;
   ebt_rec_s rec;
   ebt_buf_if rec_in ();
   ebt_buf_if rec_out ();

   assign rst_n = st_q.rst_sync[1];

   // Breakpoint addresses; written whenever I_BP_WR is set with an index below NBP, in any state.
   always_ff @(posedge I_SYS_CLK) begin
      if (I_BP_WR && (I_BP_IDX < NBP[3:0])) begin
         bp_mem[I_BP_IDX] <= I_BP_ADDR; // RULE2
      end
   end

   // One comparator per breakpoint slot.
   for (genvar g = 0; g < NBP; g++) begin : g_cmp
      assign bp_match[g] = st_q.bp_valid[g] && (bp_mem[g] == I_ADDR); // RULE1
   end

   // Break-source decode.
   always_comb begin
      unique case (ebt_cycle_e'(I_CYC_KIND))
         EBT_CY_FETCH: cyc_sel = I_BP_CYCLE_TYPE_SELECT[SEL_FETCH]; // RULE3
         EBT_CY_READ: cyc_sel = I_BP_CYCLE_TYPE_SELECT[SEL_READ];
         EBT_CY_WRITE: cyc_sel = I_BP_CYCLE_TYPE_SELECT[SEL_WRITE];
         EBT_CY_NONE: cyc_sel = 1'b0;
      endcase
      addr_src = I_CYC_VLD && cyc_sel && st_q.bp_armed && (|bp_match); // RULE4
      sync_act = I_SYNC_IN_ZERO ^ ~I_SYNC_POLARITY_SELECT; // RULE5
      // AND mode needs both a sync level and a pending or same-cycle address hit.
      if (I_GO_CONTROL_REG[GO_SYNC_AND]) begin
         sync_src = sync_act && (st_q.addr_hit || addr_src); // RULE5
      end else begin
         sync_src = sync_act && I_GO_CONTROL_REG[GO_SYNC_EN];
      end
      strobe_low = I_EXT_POD && I_CYC_VLD && (!I_P3[P3_RD_BIT] || !I_P3[P3_WR_BIT]); // RULE8
      frame = {I_P3, I_P1, I_MISC, I_DATA, I_ADDR}; // RULE21
      trace_hit = I_TRACE_BREAK_ENABLE && I_CYC_VLD && (frame == I_TRIG_VALUE); // RULE6
   end

   // Trace record assembly; the abs and rel views are both carried.
   always_comb begin
      ts_next = st_q.ts_abs + 16'h0001;
      rec.frame = frame;
      rec.cyc = ebt_cycle_e'(I_CYC_KIND); // RULE13
      rec.first_fetch = (I_CYC_KIND == 2'(EBT_CY_FETCH)) && I_MISC[0]; // RULE18
      rec.level = I_INT_LEVEL; // RULE15
      rec.sync_ext = {I_SYNC_IN_ONE, I_SYNC_IN_ZERO, I_EXT_INPUT_ONE, I_EXT_INPUT_ZERO}; // RULE16
      rec.ts_abs = st_q.ts_abs; // RULE17
      rec.ts_rel = st_q.ts_abs - st_q.ts_last;
      rec.overflow = st_q.ovf; // RULE14
   end

   // A frame is offered for each valid cycle while capture runs; a pending overflow also offers one then.
   assign rec_in.valid = st_q.trace_on && (I_CYC_VLD || st_q.ovf); // RULE14
   assign rec_in.data = rec;
   assign rec_out.ready = I_REC_READY;

   ebt_skid u_skid (
      .clk(I_SYS_CLK),
      .rst_n(rst_n),
      .up(rec_in),
      .dn(rec_out)
   );

   // Next state of the whole unit.
   always_comb begin
      st_d = st_q;
      st_d.rst_sync = {st_q.rst_sync[0], 1'b1};
      // The timestamp counts cycles or, in time mode, every clock.
      if (st_q.running && (I_TS_TIME_MODE || I_CYC_VLD)) begin
         st_d.ts_abs = ts_next; // RULE17
         if (ts_next == TS_RESET) begin
            st_d.ovf = 1'b1; // RULE14
         end
      end
      if (rec_in.valid && rec_in.ready) begin
         st_d.ts_last = st_q.ts_abs;
         // A new overflow in the same cycle is kept pending, not lost.
         if (!(st_d.ts_abs == TS_RESET && st_d.ovf && st_q.ts_abs != TS_RESET)) begin
            st_d.ovf = 1'b0;
         end
      end
      // Timer over-run/pre-start counter; only external pods see it.
      if (st_q.tmr_cnt != 3'h0) begin
         st_d.tmr_cnt = st_q.tmr_cnt - 3'h1;
      end else begin
         st_d.tmr_run = st_q.running;
      end
      if (I_CLEAR_BREAKS_CMD) begin
         st_d.bp_valid = '0; // RULE10
      end
      if (I_BP_WR && (I_BP_IDX < NBP[3:0])) begin
         st_d.bp_valid[I_BP_IDX] = 1'b1;
      end
      unique case (st_q.state)
         EBT_IDLE, EBT_HALT: begin
            if (I_START) begin
               st_d.state = EBT_RUN;
               st_d.running = 1'b1;
               st_d.brk = 1'b0;
               st_d.trace_on = 1'b1;
               st_d.cause = EBT_SRC_NONE;
               // The mode is held until a break, so the flag rises together with the break itself.
               st_d.cond_run = I_CONDITIONAL_BREAK_CMD; // RULE11
               st_d.cond = 1'b0;
               st_d.bp_armed = I_GO_CONTROL_REG[GO_BP_EN]; // RULE4
               st_d.addr_hit = 1'b0;
               st_d.trace_lag = '0;
               st_d.trace_pend = 1'b0;
               if (!I_BP_WR) begin
                  st_d.bp_valid = st_q.bp_valid; // patterns loaded before start survive
               end
               // Timers start on the same clock as the run on external pods, one clock later otherwise.
               st_d.tmr_run = I_EXT_POD; // RULE19
               st_d.tmr_cnt = I_EXT_POD ? 3'(TIMER_PRESTART_CYC) : 3'h0; // RULE20
            end
         end
         EBT_RUN: begin
            if (addr_src) begin
               st_d.addr_hit = 1'b1;
            end
            if (trace_hit) begin
               st_d.trace_pend = 1'b1;
            end
            if (st_q.trace_pend && I_CYC_VLD && I_CYC_KIND == 2'(EBT_CY_FETCH)) begin
               st_d.trace_lag = st_q.trace_lag + 2'h1; // RULE7
            end
            // Priority: stop request, strobe, sync, trace, then address.
            if (I_STOP_REQ) begin
               st_d.cause = EBT_SRC_STOP; // RULE12
            end else if (strobe_low) begin
               st_d.cause = EBT_SRC_STROBE; // RULE8
            end else if (sync_src) begin
               st_d.cause = EBT_SRC_SYNC; // RULE5
            end else if (st_q.trace_pend && st_q.trace_lag == 2'(TRACE_LAG_FETCHES)) begin
               st_d.cause = EBT_SRC_TRACE; // RULE7
            end else if (st_q.addr_hit && I_CYC_VLD && I_CYC_KIND == 2'(EBT_CY_FETCH)
                         && !I_GO_CONTROL_REG[GO_SYNC_AND]) begin
               st_d.cause = EBT_SRC_ADDR; // RULE9
            end
            if (st_d.cause != EBT_SRC_NONE) begin
               st_d.state = EBT_HALT; // RULE23
               st_d.running = 1'b0;
               st_d.brk = 1'b1;
               st_d.cond = st_q.cond_run; // RULE11
               st_d.trace_on = 1'b0; // RULE22
               st_d.tmr_run = I_EXT_POD; // RULE19
               st_d.tmr_cnt = I_EXT_POD ? 3'(TIMER_OVERRUN_CYC) : 3'h0; // RULE20
            end
         end
      endcase
      if (I_START) begin
         st_d.bp_valid = I_CLEAR_BREAKS_CMD ? '0 : st_d.bp_valid; // RULE10
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs come from flip-flops or the buffer's registered entries.
   assign O_REC_VALID = rec_out.valid;
   assign O_REC_DATA = rec_out.data;
   assign O_RUNNING = st_q.running;
   assign O_BREAK = st_q.brk;
   assign O_BREAK_CAUSE = st_q.cause;
   assign O_COND_BREAK = st_q.cond; // RULE11
   assign O_TIMER_RUN = st_q.tmr_run;
   assign O_TRACE_ON = st_q.trace_on;

   // Break checks look one cycle after the deciding edge, when the cause register has settled.
   AST_STOP_HALTS: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n) // RULE12
      (st_q.state == EBT_RUN && I_STOP_REQ) |=> (!O_RUNNING && O_BREAK_CAUSE == EBT_SRC_STOP))
      else $error("Stop request did not halt.");

   AST_HALT_STOPS_TRACE: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n) // RULE22
      $fell(O_RUNNING) |-> !O_TRACE_ON)
      else $error("Trace still on after halt.");

   AST_UNARMED_NO_ADDR: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n) // RULE4
      !st_q.bp_armed |-> !addr_src)
      else $error("Address break while unarmed.");

   AST_STROBE_BREAK: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n) // RULE8
      (st_q.state == EBT_RUN && !I_STOP_REQ && strobe_low) |=> O_BREAK_CAUSE == EBT_SRC_STROBE)
      else $error("Strobe-low break missing.");

   AST_CAUSE_WITH_BREAK: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n) // RULE23
      O_BREAK |-> O_BREAK_CAUSE != EBT_SRC_NONE)
      else $error("Break without latched cause.");

   AST_CLEAR_BP: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n) // RULE10
      (I_CLEAR_BREAKS_CMD && !I_BP_WR) |=> st_q.bp_valid == '0)
      else $error("Breakpoints not cleared.");

   AST_NO_TMR_SKEW: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n) // RULE20
      (!I_EXT_POD && $fell(st_q.running)) |-> ##1 !O_TIMER_RUN)
      else $error("Timer over-run on internal pod.");

   AST_OVF_OFFER: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n) // RULE14
      (st_q.ovf && st_q.trace_on) |-> rec_in.valid && rec.overflow)
      else $error("Overflow frame not offered.");

   // Lower-priority causes: sync must win when nothing above it is active; trace and address breaks land at the right fetch.
   AST_SYNC_BREAK: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n) // RULE5
      (st_q.state == EBT_RUN && !I_STOP_REQ && !strobe_low && sync_src) |=> O_BREAK_CAUSE == EBT_SRC_SYNC)
      else $error("Sync break missing.");

   AST_TRACE_LATE: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n) // RULE7
      ($rose(O_BREAK) && O_BREAK_CAUSE == EBT_SRC_TRACE) |-> $past(st_q.trace_lag) == 2'(TRACE_LAG_FETCHES))
      else $error("Trace break not delayed by the fetch lag.");

   AST_ADDR_AFTER_FETCH: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n) // RULE9
      ($rose(O_BREAK) && O_BREAK_CAUSE == EBT_SRC_ADDR)
      |-> ($past(st_q.addr_hit) && $past(I_CYC_KIND) == 2'(EBT_CY_FETCH)))
      else $error("Address break not at the following fetch.");

   // Run control, capture and timers.
   AST_START_ARMS: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n) // RULE4
      (st_q.state != EBT_RUN && I_START) |=> st_q.bp_armed == $past(I_GO_CONTROL_REG[GO_BP_EN]))
      else $error("Breakpoint arming not taken at start.");

   AST_COND_ONLY_BREAK: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n) // RULE11
      O_COND_BREAK |-> O_BREAK)
      else $error("Conditional flag without a break.");

   AST_NO_CAPTURE_HALTED: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n) // RULE22
      (st_q.state != EBT_RUN) |-> !rec_in.valid)
      else $error("Frame offered while halted.");

   AST_TIMER_IDLE: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n) // RULE20
      (!I_EXT_POD && !O_RUNNING && st_q.tmr_cnt == 3'h0) |=> !O_TIMER_RUN)
      else $error("Timer running while stopped on internal pod.");

   AST_OVF_SET: assert property (@(posedge I_SYS_CLK) disable iff (!rst_n) // RULE14
      (st_q.running && I_TS_TIME_MODE && st_q.ts_abs == '1) |=> st_q.ovf)
      else $error("Timestamp overflow not flagged.");

   // Main scenarios; a miss here points at a stimulus gap rather than a logic fault.
   COV_ADDR: cover property (@(posedge I_SYS_CLK) disable iff (!rst_n) O_BREAK_CAUSE == EBT_SRC_ADDR);
   COV_TRACE: cover property (@(posedge I_SYS_CLK) disable iff (!rst_n) O_BREAK_CAUSE == EBT_SRC_TRACE);
   COV_SYNC: cover property (@(posedge I_SYS_CLK) disable iff (!rst_n) O_BREAK_CAUSE == EBT_SRC_SYNC);
   COV_STROBE: cover property (@(posedge I_SYS_CLK) disable iff (!rst_n) O_BREAK_CAUSE == EBT_SRC_STROBE);
   COV_STALL: cover property (@(posedge I_SYS_CLK) disable iff (!rst_n) O_REC_VALID && !I_REC_READY);
endmodule

// ==== tb/ebt_tgt_model.sv ====
/*
 * Target bus model for the break and trace unit: issues fetch and data cycles and notes each expected record.
 * Assumes the bench samples o_note_vld at every rising edge and keeps the record buffer from filling.
 */
module ebt_tgt_model
   import ebt_pkg::*;
(
   // Control from the bench.
   input wire logic i_clk,
   input wire logic i_run,
   input wire logic i_trace_on,
   input wire logic i_full,
   input wire logic i_rand_en,
   input wire logic i_wr,
   input wire logic i_strobe_low,
   input wire logic i_pc_load,
   input wire logic i_sync0,
   // Bus cycle towards the unit.
   output logic o_vld,
   output logic [1:0] o_kind,
   output logic [ADDR_W-1:0] o_addr,
   output logic [DATA_W-1:0] o_data,
   output logic [MISC_W-1:0] o_misc,
   output logic [PORT_W-1:0] o_p1,
   output logic [PORT_W-1:0] o_p3,
   output logic [LVL_W-1:0] o_lvl,
   output logic [2:0] o_sx,
   // Expected record.
   output logic o_note_vld,
   output ebt_rec_s o_note
);
   logic [ADDR_W-1:0] pc_q;
   logic [1:0] ph_q;
   logic [1:0] cnt_q;
   logic [31:0] r;
   logic fe;

   // Known values at time zero; strobes idle high.
   initial begin
      {o_vld, o_kind, o_addr, o_data, o_misc, o_p1, o_lvl, o_sx, o_note_vld, o_note} = '0;
      {pc_q, ph_q, cnt_q} = '0;
      o_p3 = 8'hc0;
   end

   // One cycle per four clocks, so a break always lands before the next issue.
   always @(posedge i_clk) begin
      r = $urandom;
      fe = (ph_q != 2'h2);
      cnt_q <= cnt_q + 2'h1;
      o_note_vld <= o_vld && i_trace_on;
      o_note <= '{overflow: 1'b0, cyc: ebt_cycle_e'(o_kind), first_fetch: o_kind == 2'h1 && o_misc[0],
                  level: o_lvl, sync_ext: {o_sx[2], i_sync0, o_sx[1:0]},
                  frame: {o_p3, o_p1, o_misc, o_data, o_addr}, ts_abs: '0, ts_rel: '0};
      o_vld <= 1'b0;
      // A released bus shows no stale address or data.
      o_addr <= ~o_addr;
      o_data <= ~o_data;
      o_p3 <= {~i_strobe_low, 1'b1, o_p3[5:0]};
      if (i_pc_load) begin
         pc_q <= 16'h0100;
         ph_q <= 2'h0;
      end else if (i_run && cnt_q == 2'h3 && !i_full) begin
         o_vld <= 1'b1;
         ph_q <= fe ? ph_q + 2'h1 : 2'h0;
         o_kind <= fe ? 2'h1 : (i_wr ? 2'h3 : 2'h2);
         o_addr <= fe ? pc_q : 16'h8000;
         if (fe) begin
            pc_q <= pc_q + 16'h1;
         end
         o_data <= i_rand_en ? r[7:0] : 8'h00;
         o_p1 <= i_rand_en ? r[15:8] : 8'h00;
         o_misc <= {i_rand_en ? r[22:16] : 7'h00, fe | (i_rand_en & r[23])};
         o_p3 <= {~i_strobe_low, 1'b1, i_rand_en ? r[29:24] : 6'h00};
         o_lvl <= r[31:29];
         o_sx <= {r[30], r[25], r[20]};
      end
   end
endmodule

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench for the break and trace unit.
 * Assumes the target model issues bus cycles and the record sink stalls at random.
 */
module tb_top
   import ebt_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, arst_n = 1'b0, start = 1'b0, stop_req = 1'b0, clr = 1'b0, cond = 1'b0, bp_wr = 1'b0;
   logic pol = 1'b0, tbe = 1'b0, pod = 1'b0, tsm = 1'b0, rec_ready = 1'b0, rand_en = 1'b1, wr = 1'b0;
   logic sl = 1'b0, pc_load = 1'b0, sync0 = 1'b1, brk_q = 1'b0;
   logic [3:0] bp_idx = '0;
   logic [15:0] bp_addr = '0, last_fa = '0, prev_ts = '0;
   logic [2:0] sel = '0, go = '0, sx;
   logic [47:0] trig = '0;
   logic vld, running, brk, cond_brk, trace_on, rec_valid, note_vld, timer_run;
   logic [1:0] kind;
   logic [15:0] addr;
   logic [7:0] data, misc, p1, p3;
   logic [2:0] lvl;
   ebt_rec_s rec_data, note, e;
   ebt_src_e cause;
   ebt_rec_s rq[$];
   ebt_src_e bq[$];
   int err_count = 0, check_count = 0;

   ebt_unit i_ebt_unit (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_START(start), .I_STOP_REQ(stop_req),
      .I_CLEAR_BREAKS_CMD(clr), .I_CONDITIONAL_BREAK_CMD(cond), .I_BP_WR(bp_wr), .I_BP_IDX(bp_idx),
      .I_BP_ADDR(bp_addr), .I_BP_CYCLE_TYPE_SELECT(sel), .I_GO_CONTROL_REG(go), .I_SYNC_POLARITY_SELECT(pol),
      .I_TRACE_BREAK_ENABLE(tbe), .I_TRIG_VALUE(trig), .I_EXT_POD(pod), .I_TS_TIME_MODE(tsm), .I_CYC_VLD(vld),
      .I_CYC_KIND(kind), .I_ADDR(addr), .I_DATA(data), .I_MISC(misc), .I_P1(p1), .I_P3(p3), .I_INT_LEVEL(lvl),
      .I_SYNC_IN_ZERO(sync0), .I_SYNC_IN_ONE(sx[2]), .I_EXT_INPUT_ZERO(sx[0]), .I_EXT_INPUT_ONE(sx[1]),
      .I_REC_READY(rec_ready), .O_REC_VALID(rec_valid), .O_REC_DATA(rec_data), .O_RUNNING(running),
      .O_BREAK(brk), .O_BREAK_CAUSE(cause), .O_COND_BREAK(cond_brk), .O_TIMER_RUN(timer_run),
      .O_TRACE_ON(trace_on));

   ebt_tgt_model i_ebt_tgt_model (.i_clk(clk), .i_run(running), .i_trace_on(trace_on),
      .i_full(rq.size() + note_vld >= 2), .i_rand_en(rand_en), .i_wr(wr), .i_strobe_low(sl), .i_pc_load(pc_load),
      .i_sync0(sync0), .o_vld(vld), .o_kind(kind), .o_addr(addr), .o_data(data), .o_misc(misc), .o_p1(p1),
      .o_p3(p3), .o_lvl(lvl), .o_sx(sx), .o_note_vld(note_vld), .o_note(note));

   // Free-running system clock.
   always #(CLK_PERIOD_NS / 2) clk = ~clk;

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Monitor: queue notes, compare records on handshake and the cause on each new break.
   always @(posedge clk) begin
      rec_ready <= 1'($urandom_range(0, 1));
      brk_q <= brk;
      if (note_vld) rq.push_back(note);
      if (rec_valid === 1'b1 && rec_ready) begin
         e = (rq.size() > 0) ? rq.pop_front() : '1;
         chk(64'(rec_data >> 32), 64'(e >> 32));
         chk(rec_data.ts_rel, 16'(rec_data.ts_abs - prev_ts));
         prev_ts = rec_data.ts_abs;
         // Updated at once, so the drain loop sees the last fetch as soon as the queue is empty.
         if (rec_data.cyc == EBT_CY_FETCH) last_fa = rec_data.frame[15:0];
      end
      if (brk === 1'b1 && brk_q !== 1'b1) chk(cause, (bq.size() > 0) ? bq.pop_front() : 3'h7);
   end

   task automatic wreg(input logic [3:0] i, input logic [15:0] a);
      bp_wr <= 1'b1;
      bp_idx <= i;
      bp_addr <= a;
      tick(1);
      bp_wr <= 1'b0;
      tick(1);
   endtask

   task automatic launch(input logic [2:0] s, input logic [2:0] g, input logic c);
      sel <= s;
      go <= g;
      cond <= c;
      tsm <= ~tsm;
      start <= 1'b1;
      pc_load <= 1'b1;
      tick(1);
      start <= 1'b0;
      pc_load <= 1'b0;
      tick(1);
   endtask

   // Applies the trigger, bounds the wait for the halt, then drains the trace.
   task automatic halt(input ebt_src_e act, input ebt_src_e exp, input logic [15:0] fa, input logic c);
      int i;
      bq.push_back(exp);
      tick(100);
      if (act == EBT_SRC_SYNC) sync0 <= pol;
      if (act == EBT_SRC_STROBE) sl <= 1'b1;
      if (exp == EBT_SRC_STOP) begin
         tick(40);
         stop_req <= 1'b1;
         tick(1);
         stop_req <= 1'b0;
      end
      for (i = 0; i < 400 && brk !== 1'b1; i++) tick(1);
      if (i == 400) begin
         err_count++;
         finish_test();
      end
      tick(1);
      chk({running, trace_on}, 2'b00);
      chk(timer_run, pod);
      if (exp == EBT_SRC_ADDR) chk(cond_brk, c);
      // External pods let the timers over-run a few cycles; every pod has them stopped soon after.
      tick(3);
      chk(timer_run, 1'b0);
      sl <= 1'b0;
      sync0 <= ~pol;
      for (i = 0; i < 400 && (rq.size() > 0 || note_vld); i++) tick(1);
      chk(rq.size() + bq.size(), 0);
      if (fa != 16'h0) chk(last_fa, fa);
   endtask

   task automatic bp_run(input logic [2:0] s, input logic w, input logic [2:0] g, input logic c, input logic ce,
                         input logic bad, input ebt_src_e exp, input logic [15:0] fa);
      wr <= w;
      if (bad) wreg(4'ha, 16'h0105);
      else begin
         wreg(4'h0, 16'h0105);
         wreg(4'h9, 16'h8000);
      end
      if (ce) begin
         clr <= 1'b1;
         tick(1);
         clr <= 1'b0;
         tick(1);
      end
      launch(s, g, c);
      halt(EBT_SRC_NONE, exp, fa, c);
   endtask

   // Main sequence.
   initial begin
      void'($urandom(60942));
      tick(4);
      arst_n <= 1'b1;
      tick(3);
      bp_run(3'h1, 1'b0, 3'h1, 1'b1, 1'b0, 1'b0, EBT_SRC_ADDR, 16'h0106);
      bp_run(3'h2, 1'b0, 3'h1, 1'b0, 1'b0, 1'b0, EBT_SRC_ADDR, 16'h0102);
      bp_run(3'h4, 1'b1, 3'h1, 1'b0, 1'b0, 1'b0, EBT_SRC_ADDR, 16'h0102);
      bp_run(3'h4, 1'b0, 3'h1, 1'b0, 1'b0, 1'b0, EBT_SRC_STOP, 16'h0);
      bp_run(3'h1, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0, EBT_SRC_STOP, 16'h0);
      bp_run(3'h7, 1'b1, 3'h1, 1'b0, 1'b1, 1'b0, EBT_SRC_STOP, 16'h0);
      bp_run(3'h1, 1'b0, 3'h1, 1'b0, 1'b0, 1'b1, EBT_SRC_STOP, 16'h0);
      for (int p = 0; p < 2; p++) begin
         pol <= p[0];
         sync0 <= ~p[0];
         tick(2);
         launch(3'h0, 3'h2, 1'b0);
         halt(EBT_SRC_SYNC, EBT_SRC_SYNC, 16'h0, 1'b0);
      end
      for (int p = 0; p < 2; p++) begin
         pod <= p[0];
         launch(3'h0, 3'h0, 1'b0);
         halt(EBT_SRC_STROBE, (p != 0) ? EBT_SRC_STROBE : EBT_SRC_STOP, 16'h0, 1'b0);
      end
      pod <= 1'b0;
      rand_en <= 1'b0;
      tbe <= 1'b1;
      trig <= {8'hc0, 8'h00, 8'h01, 8'h00, 16'h0103};
      launch(3'h0, 3'h0, 1'b0);
      halt(EBT_SRC_NONE, EBT_SRC_TRACE, 16'h0105, 1'b0);
      finish_test();
   end
endmodule
